/* rtl/osm_osc_mode_select.v */
`timescale 1ns/1ps
`include "osm_defines.vh"

module osm_osc_mode_select #(
  parameter [3:0] CODE_LP = 4'h0,
  parameter [3:0] CODE_XT = 4'h1,
  parameter [3:0] CODE_HS = 4'h2,
  parameter [3:0] CODE_RC = 4'h3,
  parameter [3:0] CODE_EC = 4'h4,
  parameter [3:0] CODE_EXT_CLOCK_IO_MODE = 4'h5,
  parameter [3:0] CODE_RESISTOR_CAP_IO_MODE = 4'h7,
  parameter integer OST_PERIODS = `OSM_OST_PERIODS
) (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire [3:0] i_osc_mode_field,
  input wire i_wake,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_xtal_osc,
  input wire i_rc_osc,
  input wire i_internal_8mhz_source,
  input wire i_clock_in_pin,
  output reg o_clock_in_pin,
  output reg o_clock_in_pin_oe,
  input wire i_clock_out_pin,
  output reg o_clock_out_pin,
  output reg o_clock_out_pin_oe,
  input wire i_port_a_bit6_out,
  input wire i_port_a_bit6_oe,
  input wire i_port_a_bit7_out,
  input wire i_port_a_bit7_oe,
  output reg o_port_a_bit6_in,
  output reg o_port_a_bit7_in,
  output reg [1:0] o_clk_src,
  output reg o_pll_on,
  output reg o_xtal_drive_en,
  output reg o_clock_ready
);

  localparam [3:0] M_LP = 4'h0;
  localparam [3:0] M_XT = 4'h1;
  localparam [3:0] M_HS = 4'h2;
  localparam [3:0] M_HIGH_SPEED_CRYSTAL_PLL_MODE = 4'h3;
  localparam [3:0] M_RC = 4'h4;
  localparam [3:0] M_RESISTOR_CAP_IO_MODE = 4'h5;
  localparam [3:0] M_INT_CLKOUT = 4'h6;
  localparam [3:0] M_INT_IO = 4'h7;
  localparam [3:0] M_EC = 4'h8;
  localparam [3:0] M_EXT_CLOCK_IO_MODE = 4'h9;

  localparam [1:0] ST_LOAD = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  reg [1:0] state;
  reg [3:0] mode_code;
  reg [3:0] mode;
  reg [7:0] tune;
  reg [7:0] ctrl;
  reg [10:0] ost_cnt;
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg src_prev;
  reg [1:0] pin_sync1;
  reg [1:0] pin_sync2;

  reg [3:0] next_mode;
  reg [1:0] next_src;
  reg next_clkout;
  reg next_bit6_io;
  reg next_bit7_io;
  reg next_xtal;
  reg next_ext;
  reg src_level;
  reg [7:0] next_rdata;

  wire int_mode;
  wire fsel_ok;
  wire pll_avail;
  wire pll_hw;
  wire pll_now;
  wire src_tick;
  wire div_level;
  wire [7:0] status;

  // decode the stored code into a mode; unknown codes go to full I/O internal
  always @* begin
    if (mode_code == CODE_LP) begin
      next_mode = M_LP;
    end else if (mode_code == CODE_XT) begin
      next_mode = M_XT;
    end else if (mode_code == CODE_HS) begin
      next_mode = M_HS;
    end else if (mode_code == `OSM_CODE_HIGH_SPEED_CRYSTAL_PLL_MODE) begin
      next_mode = M_HIGH_SPEED_CRYSTAL_PLL_MODE;
    end else if (mode_code == CODE_RC) begin
      next_mode = M_RC;
    end else if (mode_code == CODE_RESISTOR_CAP_IO_MODE) begin
      next_mode = M_RESISTOR_CAP_IO_MODE;
    end else if (mode_code == `OSM_CODE_INT_CLKOUT) begin
      next_mode = M_INT_CLKOUT;
    end else if (mode_code == CODE_EC) begin
      next_mode = M_EC;
    end else if (mode_code == CODE_EXT_CLOCK_IO_MODE) begin
      next_mode = M_EXT_CLOCK_IO_MODE;
    end else begin
      // safe choice: puts no clock on a pin and needs no external part
      next_mode = M_INT_IO;
    end
  end

  // per-mode source and pin roles
  always @* begin
    next_src = `OSM_SRC_XTAL;
    next_clkout = 1'b0;
    next_bit6_io = 1'b0;
    next_bit7_io = 1'b0;
    next_xtal = 1'b0;
    next_ext = 1'b0;
    case (mode)
      M_LP, M_XT, M_HS, M_HIGH_SPEED_CRYSTAL_PLL_MODE: begin
        next_xtal = 1'b1;
      end
      M_RC: begin
        next_src = `OSM_SRC_RC;
        next_clkout = 1'b1;
      end
      M_RESISTOR_CAP_IO_MODE: begin
        next_src = `OSM_SRC_RC;
        next_bit6_io = 1'b1;
      end
      M_INT_CLKOUT: begin
        next_src = `OSM_SRC_INT;
        next_clkout = 1'b1;
        next_bit7_io = 1'b1;
      end
      M_INT_IO: begin
        next_src = `OSM_SRC_INT;
        next_bit6_io = 1'b1;
        next_bit7_io = 1'b1;
      end
      M_EC: begin
        next_src = `OSM_SRC_EXT;
        next_ext = 1'b1;
        next_clkout = 1'b1;
      end
      M_EXT_CLOCK_IO_MODE: begin
        next_src = `OSM_SRC_EXT;
        next_ext = 1'b1;
        next_bit6_io = 1'b1;
      end
      default: begin
        next_src = `OSM_SRC_INT;
        next_bit6_io = 1'b1;
        next_bit7_io = 1'b1;
      end
    endcase
  end

  assign int_mode = (mode == M_INT_CLKOUT) || (mode == M_INT_IO);
  assign fsel_ok = (ctrl[`OSM_CTRL_FSEL_HI:`OSM_CTRL_FSEL_LO] == `OSM_FSEL_8MHZ) ||
                   (ctrl[`OSM_CTRL_FSEL_HI:`OSM_CTRL_FSEL_LO] == `OSM_FSEL_4MHZ);
  assign pll_avail = int_mode && fsel_ok;
  // hardware-enabled multiplier ignores the software bit
  assign pll_hw = (mode == M_HIGH_SPEED_CRYSTAL_PLL_MODE);
  assign pll_now = pll_hw || (pll_avail && tune[`OSM_TUNE_MULT_EN]);

  // pins from outside pass two flops before any use
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      pin_sync1 <= 2'h0;
      pin_sync2 <= 2'h0;
      src_prev <= 1'b0;
    end else begin
      sync1 <= {i_internal_8mhz_source, i_clock_in_pin, i_rc_osc, i_xtal_osc};
      sync2 <= sync1;
      pin_sync1 <= {i_clock_in_pin, i_clock_out_pin};
      pin_sync2 <= pin_sync1;
      src_prev <= src_level;
    end
  end

  // external mode runs from clock_in_pin after its two sync flops (sync2[2])
  always @* begin
    case (o_clk_src)
      `OSM_SRC_XTAL: src_level = sync2[0];
      `OSM_SRC_RC: src_level = sync2[1];
      `OSM_SRC_EXT: src_level = sync2[2];
      `OSM_SRC_INT: src_level = sync2[3];
      default: src_level = 1'b0;
    endcase
  end

  // both edges count, so four of them are two source periods
  assign src_tick = (src_level != src_prev);

  // mode field is latched once after reset release; changes need a reset
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_LOAD;
      mode_code <= 4'h0;
      mode <= M_INT_IO;
      ost_cnt <= 11'h000;
      o_clock_ready <= 1'b0;
    end else begin
      mode <= next_mode;
      case (state)
        ST_LOAD: begin
          mode_code <= i_osc_mode_field;
          state <= ST_START;
          ost_cnt <= 11'h000;
        end
        ST_START: begin
          if (next_ext) begin
            state <= ST_RUN;
            o_clock_ready <= 1'b1;
          end else if (src_tick) begin
            if (ost_cnt >= OST_PERIODS[10:0] * 11'h002 - 11'h001) begin
              state <= ST_RUN;
              o_clock_ready <= 1'b1;
            end else begin
              ost_cnt <= ost_cnt + 11'h001;
            end
          end
        end
        ST_RUN: begin
          // a wake restarts the wait, which external modes skip
          if (i_wake && !next_ext) begin
            state <= ST_START;
            ost_cnt <= 11'h000;
            o_clock_ready <= 1'b0;
          end
        end
        default: begin
          state <= ST_LOAD;
          o_clock_ready <= 1'b0;
        end
      endcase
    end
  end

  osm_quarter_div u_div (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(src_tick),
    .i_pll_on(pll_now),
    .i_run(state == ST_RUN),
    .o_level(div_level)
  );

  // software registers
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tune <= `OSM_TUNE_RESET;
      ctrl <= `OSM_CTRL_RESET;
    end else begin
      if (i_wr && i_addr == `OSM_ADDR_TUNE) begin
        tune[`OSM_TUNE_INTSRC] <= i_wdata[`OSM_TUNE_INTSRC];
        tune[`OSM_TUNE_MULT_EN] <= i_wdata[`OSM_TUNE_MULT_EN] & pll_avail;
        tune[5] <= 1'b0;
        tune[`OSM_TUNE_TUN_HI:`OSM_TUNE_TUN_LO] <= i_wdata[`OSM_TUNE_TUN_HI:`OSM_TUNE_TUN_LO];
      end else if (!pll_avail) begin
        tune[`OSM_TUNE_MULT_EN] <= 1'b0;
      end
      if (i_wr && i_addr == `OSM_ADDR_CTRL) begin
        ctrl[`OSM_CTRL_FSEL_HI:`OSM_CTRL_FSEL_LO] <=
          i_wdata[`OSM_CTRL_FSEL_HI:`OSM_CTRL_FSEL_LO];
      end
    end
  end

  assign status = {o_clk_src, next_bit7_io, next_bit6_io, next_clkout, pll_hw,
                   o_pll_on, o_clock_ready};

  always @* begin
    case (i_addr)
      `OSM_ADDR_CFG: next_rdata = {4'h0, mode_code};
      // read mask keeps the bit at zero where the multiplier is unavailable
      `OSM_ADDR_TUNE: next_rdata = {tune[7], tune[6] & pll_avail, tune[5:0]};
      `OSM_ADDR_CTRL: next_rdata = ctrl;
      `OSM_ADDR_STAT: next_rdata = status;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // pin muxing and clock status outputs
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_src <= `OSM_SRC_INT;
      o_pll_on <= 1'b0;
      o_xtal_drive_en <= 1'b0;
      o_clock_out_pin <= 1'b0;
      o_clock_out_pin_oe <= 1'b0;
      o_clock_in_pin <= 1'b0;
      o_clock_in_pin_oe <= 1'b0;
      o_port_a_bit6_in <= 1'b0;
      o_port_a_bit7_in <= 1'b0;
    end else begin
      o_clk_src <= next_src;
      o_pll_on <= pll_now;
      // crystal driver owns both pins, so neither is ever driven as logic
      o_xtal_drive_en <= next_xtal;
      if (next_clkout) begin
        o_clock_out_pin <= div_level;
        o_clock_out_pin_oe <= (state == ST_RUN);
      end else if (next_bit6_io) begin
        o_clock_out_pin <= i_port_a_bit6_out;
        o_clock_out_pin_oe <= i_port_a_bit6_oe;
      end else begin
        o_clock_out_pin <= 1'b0;
        o_clock_out_pin_oe <= 1'b0;
      end
      if (next_bit7_io) begin
        o_clock_in_pin <= i_port_a_bit7_out;
        o_clock_in_pin_oe <= i_port_a_bit7_oe;
      end else begin
        o_clock_in_pin <= 1'b0;
        o_clock_in_pin_oe <= 1'b0;
      end
      o_port_a_bit6_in <= next_bit6_io & pin_sync2[0];
      o_port_a_bit7_in <= next_bit7_io & pin_sync2[1];
    end
  end

endmodule // osm_osc_mode_select

/* rtl/osm_defines.vh */
`ifndef OSM_DEFINES_VH
`define OSM_DEFINES_VH

// register byte offsets
`define OSM_ADDR_CFG 4'h0
`define OSM_ADDR_TUNE 4'h4
`define OSM_ADDR_CTRL 4'h8
`define OSM_ADDR_STAT 4'hC

// oscillator_tuning_reg fields
`define OSM_TUNE_INTSRC 7
`define OSM_TUNE_MULT_EN 6
`define OSM_TUNE_TUN_HI 4
`define OSM_TUNE_TUN_LO 0
`define OSM_TUNE_RESET 8'h00

// oscillator_control_reg frequency select field
`define OSM_CTRL_FSEL_HI 6
`define OSM_CTRL_FSEL_LO 4
`define OSM_CTRL_RESET 8'h00
`define OSM_FSEL_8MHZ 3'h7
`define OSM_FSEL_4MHZ 3'h6

// status register fields
`define OSM_STAT_READY 0
`define OSM_STAT_PLL_ON 1
`define OSM_STAT_PLL_HW 2
`define OSM_STAT_CLKOUT 3
`define OSM_STAT_BIT6_IO 4
`define OSM_STAT_BIT7_IO 5
`define OSM_STAT_SRC_HI 7
`define OSM_STAT_SRC_LO 6

// osc_mode_field codes that are fixed
`define OSM_CODE_HIGH_SPEED_CRYSTAL_PLL_MODE 4'h6
`define OSM_CODE_INT_CLKOUT 4'h9
`define OSM_CODE_INT_IO 4'h8

// clock source encoding
`define OSM_SRC_XTAL 2'h0
`define OSM_SRC_RC 2'h1
`define OSM_SRC_EXT 2'h2
`define OSM_SRC_INT 2'h3

// multiplier factor and clock-out divide
`define OSM_PLL_FACTOR 4
`define OSM_CLKOUT_DIV 4
// source transitions per clock-out toggle (two edges per period)
`define OSM_TOGGLE_PLAIN 3'h4
`define OSM_TOGGLE_PLL 3'h1

// oscillator start-up wait in source periods
`define OSM_OST_PERIODS 1024

`endif

/* rtl/osm_quarter_div.v */
`timescale 1ns/1ps
`include "osm_defines.vh"

// turns transitions of the oscillator into a core-clock/4 level
module osm_quarter_div (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire i_tick,
  input wire i_pll_on,
  input wire i_run,
  output reg o_level
);

  reg [2:0] cnt;
  wire [2:0] limit;

  // with the x4 multiplier the core/4 rate equals the source rate
  assign limit = i_pll_on ? `OSM_TOGGLE_PLL : `OSM_TOGGLE_PLAIN;

  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= 3'h0;
      o_level <= 1'b0;
    end else if (!i_run) begin
      cnt <= 3'h0;
      o_level <= 1'b0;
    end else if (i_tick) begin
      if (cnt + 3'h1 >= limit) begin
        cnt <= 3'h0;
        o_level <= ~o_level;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end

endmodule // osm_quarter_div

/* sim/osm_osc_model.sv */
`timescale 1ns/1ps
// free-running source well below the sync rate so every edge is seen
module osm_osc_model #(
  parameter integer HALF = 4
) (
  input wire i_sys_clk,
  output reg o_level
);
  integer cnt = 0;
  initial o_level = 1'b0;
  always @(posedge i_sys_clk) begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0) o_level <= ~o_level;
  end
endmodule // osm_osc_model

/* sim/osm_chk_assertions.sv */
`timescale 1ns/1ps
`include "osm_defines.vh"
module osm_chk (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire [3:0] i_osc_mode_field,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_port_a_bit6_out,
  input wire i_port_a_bit6_oe,
  input wire i_port_a_bit7_out,
  input wire i_port_a_bit7_oe,
  input wire o_clock_in_pin,
  input wire o_clock_in_pin_oe,
  input wire o_clock_out_pin,
  input wire o_clock_out_pin_oe,
  input wire [1:0] o_clk_src,
  input wire o_pll_on,
  input wire o_xtal_drive_en,
  input wire o_clock_ready
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // pin roles settle a few edges after release
  reg [1:0] up;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  wire m8 = i_osc_mode_field == `OSM_CODE_INT_IO;
  wire m9 = i_osc_mode_field == `OSM_CODE_INT_CLKOUT;
  pll_gate_a: assert property (o_pll_on |->
    i_osc_mode_field == `OSM_CODE_HIGH_SPEED_CRYSTAL_PLL_MODE || o_clk_src == `OSM_SRC_INT) else $error("pll on");
  xtal_pins_a: assert property (o_clk_src == `OSM_SRC_XTAL |->
    !o_clock_out_pin_oe && !o_clock_in_pin_oe) else $error("crystal pin driven");
  xtal_drive_a: assert property (o_xtal_drive_en |-> o_clk_src == `OSM_SRC_XTAL)
    else $error("crystal drive");
  ext_fast_a: assert property (o_clk_src == `OSM_SRC_EXT |-> ##[0:2] o_clock_ready)
    else $error("ext not ready");
  ext_hold_a: assert property (o_clk_src == `OSM_SRC_EXT && o_clock_ready |=>
    o_clock_ready) else $error("ext ready fell");
  // pin enable is registered from the run state, one edge behind ready
  int_out_a: assert property (o_clock_ready && m9 |=> o_clock_out_pin_oe)
    else $error("no clock out");
  io6_copy_a: assert property (up == 2'h3 && m8 |->
    o_clock_out_pin_oe == $past(i_port_a_bit6_oe)) else $error("bit6 oe");
  io7_copy_a: assert property (up == 2'h3 && (m8 || m9) |->
    o_clock_in_pin == $past(i_port_a_bit7_out) && o_clock_in_pin_oe == $past(i_port_a_bit7_oe))
    else $error("bit7 copy");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata");
  cover property (o_clk_src == `OSM_SRC_EXT && o_clock_ready);
  cover property (o_pll_on && o_clk_src == `OSM_SRC_INT);
  cover property (o_rdata != 8'h00);
endmodule // osm_chk
bind osm_osc_mode_select osm_chk u_chk (.i_sys_clk, .i_sys_rst, .i_osc_mode_field, .i_rd,
  .o_rdata, .i_port_a_bit6_out, .i_port_a_bit6_oe, .i_port_a_bit7_out, .i_port_a_bit7_oe,
  .o_clock_in_pin, .o_clock_in_pin_oe, .o_clock_out_pin, .o_clock_out_pin_oe, .o_clk_src,
  .o_pll_on, .o_xtal_drive_en, .o_clock_ready);

/* sim/tb_osm_osc_mode_select.sv */
`timescale 1ns/1ps
`include "osm_defines.vh"
module tb_osm_osc_mode_select;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] mode = 4'h0;
  reg wake = 1'b0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg p6o = 1'b0;
  reg p6e = 1'b0;
  reg p7o = 1'b0;
  reg p7e = 1'b0;
  reg [31:0] seed = 32'hA922;
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer m;
  integer k;
  reg [7:0] d;
  wire [7:0] rdata;
  wire c_in, c_in_oe, c_out, c_out_oe, osc, pll, xen, rdy;
  wire [1:0] src;
  wire p6i, p7i, in_wire;
  wire out_wire = c_out_oe ? c_out : 1'b1;
  always #20 clk = ~clk;
  osm_osc_model #(.HALF(4)) u_osc (.i_sys_clk(clk), .o_level(osc));
  osm_osc_mode_select #(.OST_PERIODS(4)) dut (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_osc_mode_field(mode), .i_wake(wake), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_xtal_osc(osc), .i_rc_osc(osc),
    .i_internal_8mhz_source(osc), .i_clock_in_pin(in_wire), .o_clock_in_pin(c_in),
    .o_clock_in_pin_oe(c_in_oe), .i_clock_out_pin(out_wire), .o_clock_out_pin(c_out),
    .o_clock_out_pin_oe(c_out_oe), .i_port_a_bit6_out(p6o), .i_port_a_bit6_oe(p6e),
    .i_port_a_bit7_out(p7o), .i_port_a_bit7_oe(p7e), .o_port_a_bit6_in(p6i),
    .o_port_a_bit7_in(p7i), .o_clk_src(src), .o_pll_on(pll), .o_xtal_drive_en(xen),
    .o_clock_ready(rdy));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [1:0] exp_src(input [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h6: exp_src = 2'h0;
      4'h3, 4'h7: exp_src = 2'h1;
      4'h4, 4'h5: exp_src = 2'h2;
      default: exp_src = 2'h3;
    endcase
  endfunction
  // in internal modes the bit7 pin is plain I/O, pulled high when released
  assign in_wire = (exp_src(mode) == 2'h3) ? (c_in_oe ? c_in : 1'b1) : osc;
  task finish_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, output [7:0] v);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
    end
  endtask
  // counts pin toggles against source edges; div 1 means multiplied core
  task rate(input integer div);
    integer t, p, j;
    reg lo, lp;
    begin
      t = 0;
      p = 0;
      lo = osc;
      lp = c_out;
      for (j = 0; j < 240; j = j + 1) begin
        @(negedge clk);
        if (osc !== lo) t = t + 1;
        if (c_out !== lp) p = p + 1;
        lo = osc;
        lp = c_out;
      end
      j = p - t / div;
      chk({7'h0, j >= -1 && j <= 1}, 8'h01);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  initial begin
    for (m = 0; m < 16; m = m + 1) begin
      seed = lfsr(seed);
      @(posedge clk);
      rst <= 1'b1;
      mode <= m[3:0];
      {p6o, p6e, p7o, p7e} <= seed[3:0];
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 600 && rdy !== 1'b1; k = k + 1) @(negedge clk);
      @(negedge clk);
      d = {4'h0, exp_src(m[3:0]), m == 6, exp_src(m[3:0]) == 2'h0};
      chk({4'h0, src, pll, xen}, d);
      d = {6'h0, (m == 3 || m == 4 || m == 9) ? 1'b1 : (m == 5 || m >= 7) ? p6e : 1'b0,
        m > 7 ? p7e : 1'b0};
      chk({6'h0, c_out_oe, c_in_oe}, d);
      if (m == 5 || (m >= 7 && m != 9)) chk({7'h0, c_out}, {7'h0, p6o});
      if (m > 7) chk({7'h0, c_in}, {7'h0, p7o});
      repeat (3) @(negedge clk);
      d = {6'h0, (m == 5 || (m >= 7 && m != 9)) ? (p6e ? p6o : 1'b1) : 1'b0,
        m > 7 ? (p7e ? p7o : 1'b1) : 1'b0};
      chk({6'h0, p6i, p7i}, d);
      rd_reg(`OSM_ADDR_CFG, d);
      chk(d, {4'h0, m[3:0]});
      rd_reg(4'h2, d);
      chk(d, 8'h00);
      wr_reg(`OSM_ADDR_TUNE, seed[15:8] | 8'h40);
      rd_reg(`OSM_ADDR_TUNE, d);
      chk(d, seed[15:8] & 8'h9F);
      if (m == 3 || m == 4) rate(4);
      if (m >= 3 && m <= 5) begin
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h0, rdy}, {7'h0, m != 3});
      end
      if (m == 8 || m == 9) begin
        wr_reg(`OSM_ADDR_CTRL, seed[16] ? 8'h70 : 8'h60);
        wr_reg(`OSM_ADDR_TUNE, 8'h40);
        rd_reg(`OSM_ADDR_TUNE, d);
        chk(d, 8'h40);
        repeat (3) @(negedge clk);
        chk({7'h0, pll}, 8'h01);
        if (m == 9) rate(1);
        wr_reg(`OSM_ADDR_CTRL, 8'h50);
        repeat (3) @(negedge clk);
        rd_reg(`OSM_ADDR_TUNE, d);
        chk({d[6], pll, 6'h0}, 8'h00);
      end
    end
    finish_test;
  end
endmodule // tb_osm_osc_mode_select
